// >>> hdl/fmpl_consts.svh
// Constants for the file move / pointer load execution block.
// Assumes inclusion by its bare name from the data memory, the execution block and the testbench.
`ifndef FMPL_CONSTS_SVH
`define FMPL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map offsets (byte addresses on the register bus).
// ----------------------------------------------------------------------------
`define FMPL_OFF_CTRL      32'h0000_0000
`define FMPL_OFF_INSTR     32'h0000_0004
`define FMPL_OFF_WREG      32'h0000_0008
`define FMPL_OFF_STATUS    32'h0000_000c
`define FMPL_OFF_BANK      32'h0000_0010
`define FMPL_OFF_PTR0      32'h0000_0014
`define FMPL_OFF_PTR1      32'h0000_0018
`define FMPL_OFF_PTR2      32'h0000_001c
`define FMPL_OFF_MEMADDR   32'h0000_0020
`define FMPL_OFF_MEMDATA   32'h0000_0024
`define FMPL_OFF_STATE     32'h0000_0028

// ----------------------------------------------------------------------------
// Field positions and encodings.
// ----------------------------------------------------------------------------
`define FMPL_CTRL_EXT_BIT  0
`define FMPL_ST_N_BIT      4
`define FMPL_ST_Z_BIT      2
`define FMPL_OP_IOR        6'h04
`define FMPL_OP_MOVE_FROM_FILE       6'h14
`define FMPL_OP_LPTR       10'h3b8
`define FMPL_OP_MFF_SRC    4'hc
`define FMPL_OP_MFF_DST    4'hf
`define FMPL_IDX_LIMIT     8'h5f
`define FMPL_ACC_SPLIT     8'h60
`define FMPL_WREG_ADDR     12'hfe8
`define FMPL_PCL_ADDR      12'hff9
`define FMPL_STACK_TOP_LOW_ADDR     12'hffd
`define FMPL_STACK_TOP_UPPER_ADDR     12'hfff
`define FMPL_ACC_HI_BANK   4'hf

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define FMPL_RST_BYTE      8'h00
`define FMPL_RST_WORD      16'hffff

`endif

// >>> hdl/fmpl_pkg.sv
// Types shared by the execution block and its helpers.
// Assumes the constants header sits beside it.
package fmpl_pkg;

    // ------------------------------------------------------------------------
    // Instruction cycle phases, one-hot.
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        FMPL_Q1 = 4'h1,
        FMPL_Q2 = 4'h2,
        FMPL_Q3 = 4'h4,
        FMPL_Q4 = 4'h8
    } fmpl_phase_t;

    // Decoded operation class.
    typedef enum logic [4:0] {
        FMPL_OP_NONE  = 5'h01,
        FMPL_OP_OR    = 5'h02,
        FMPL_OP_MOVE  = 5'h04,
        FMPL_OP_PTR   = 5'h08,
        FMPL_OP_FF    = 5'h10
    } fmpl_op_t;

endpackage : fmpl_pkg

// >>> hdl/fmpl_mem_if.sv
// Interface carrying data memory accesses between the executor and memory.
// Assumes one clock domain; the executor drives, the memory answers.
`timescale 1ns/1ps
interface fmpl_mem_if;
    logic [11:0] addr;   // Resolved 12-bit data address.
    logic        we;     // Write strobe.
    logic [7:0]  wdata;  // Write data.
    logic [7:0]  rdata;  // Combinational read data.

    modport master (output addr, output we, output wdata, input rdata);
    modport slave  (input addr, input we, input wdata, output rdata);
endinterface : fmpl_mem_if

// >>> hdl/fmpl_data_mem.sv
// Flip-flop data memory addressed by a 12-bit index.
// Assumes single-cycle writes and asynchronous reads.
`timescale 1ns/1ps
`include "fmpl_consts.svh"
module fmpl_data_mem #(
    parameter int DEPTH = 4096
) (
    input  wire logic   clk_sys,  // System clock.
    input  wire logic   nrst,     // Asynchronous reset, active low.
    fmpl_mem_if.slave   mem       // Access port.
);
    logic [7:0] store_q [DEPTH];

    // Each entry clears at reset and takes write data when addressed.
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                store_q[i] <= `FMPL_RST_BYTE;
            end else if (mem.we && mem.addr == 12'(i)) begin
                store_q[i] <= mem.wdata;
            end
        end
    end

    // Reads are combinational.
    assign mem.rdata = store_q[mem.addr];
endmodule : fmpl_data_mem

// >>> hdl/fmpl_ahb_slave.sv
// AHB-Lite slave front end: turns transfers into one-cycle register strobes.
// Assumes single word transfers; always answers OKAY with no wait states.
`timescale 1ns/1ps
module fmpl_ahb_slave (
    input  wire logic        clk_sys,   // System clock.
    input  wire logic        nrst,      // Asynchronous reset, active low.
    input  wire logic        hsel,      // Slave select.
    input  wire logic [31:0] haddr,     // Address.
    input  wire logic [1:0]  htrans,    // Transfer type.
    input  wire logic        hwrite,    // Write flag.
    input  wire logic        hready,    // Bus ready.
    input  wire logic [31:0] hwdata,    // Write data.
    output logic             wr_stb,    // One-cycle write strobe.
    output logic             rd_stb,    // One-cycle read strobe in address phase.
    output logic [7:0]       wr_addr,   // Write address, low byte.
    output logic [7:0]       rd_addr,   // Read address, low byte.
    output logic [31:0]      wr_data    // Write data.
);
    logic       wpend_q;
    logic [7:0] waddr_q;

    // A write address phase is held until its data phase.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wpend_q <= 1'b0;
            waddr_q <= 8'h00;
        end else if (hready) begin
            wpend_q <= hsel && htrans[1] && hwrite;
            waddr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
        end
    end

    assign wr_stb  = wpend_q;
    assign wr_addr = waddr_q;
    assign wr_data = hwdata;
    assign rd_stb  = hready && hsel && htrans[1] && !hwrite;
    // Addresses above the low byte map to an unmapped slot so they cannot alias.
    assign rd_addr = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
endmodule : fmpl_ahb_slave

// >>> hdl/fmpl_exec.sv
// Execution block for four core data instructions, reached over AHB-Lite.
// Assumes one 125 MHz clock; software feeds instruction words and peeks memory.
//
// Overview of operation
// - OR-with-file ORs working register with addressed file; opcode 000100da ffff.
// - d equal 0 writes the result to working register; 1 writes file.
// - OR and move-from-file update negative and zero; other status bits unchanged.
// - a equal 0 resolves the address inside the fast access bank.
// - a equal 1 uses the bank select register to pick the bank.
// - a 0, extended set on, address at most 95 uses indexed offset.
// - Move-from-file, opcode 010100da ffff, copies file to d destination.
// - The 8-bit move-from-file operand reaches any byte of a 256-byte bank.
// - Pointer load puts a 12-bit literal into pointer 0, 1 or 2.
// - Pointer load first word is 1110111000ff then literal bits.
// - File-to-file move: source word prefixed 1100, destination word 1111.
// - File-to-file move may touch the working register; flags untouched.
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fmpl_consts.svh"
module fmpl_exec (
    input  wire logic        CLK_SYS,    // System clock, 125 MHz.
    input  wire logic        NRST,       // Asynchronous reset, active low.
    input  wire logic        HSEL,       // AHB slave select.
    input  wire logic [31:0] HADDR,      // AHB address.
    input  wire logic [1:0]  HTRANS,     // AHB transfer type.
    input  wire logic        HWRITE,     // AHB write flag.
    input  wire logic [2:0]  HSIZE,      // AHB size, word only.
    input  wire logic        HREADY,     // AHB bus ready.
    input  wire logic [31:0] HWDATA,     // AHB write data.
    output logic [31:0]      HRDATA,     // AHB read data.
    output logic             HREADYOUT,  // AHB ready out.
    output logic             HRESP       // AHB response, always OKAY.
);
    // ------------------------------------------------------------------------
    // Bus front end and memory.
    // ------------------------------------------------------------------------
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  wr_addr;
    logic [7:0]  rd_addr;
    logic [31:0] wr_data;

    fmpl_mem_if mem ();

    fmpl_ahb_slave u_bus (
        .clk_sys (CLK_SYS),
        .nrst    (NRST),
        .hsel    (HSEL),
        .haddr   (HADDR),
        .htrans  (HTRANS),
        .hwrite  (HWRITE),
        .hready  (HREADY),
        .hwdata  (HWDATA),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb),
        .wr_addr (wr_addr),
        .rd_addr (rd_addr),
        .wr_data (wr_data)
    );

    fmpl_data_mem #(.DEPTH(4096)) u_mem (
        .clk_sys (CLK_SYS),
        .nrst    (NRST),
        .mem     (mem.slave)
    );

    // ------------------------------------------------------------------------
    // Architectural state.
    // ------------------------------------------------------------------------
    logic [7:0]  wreg_q;
    logic [7:0]  status_q;
    logic [7:0]  bank_q;
    logic        ext_q;
    logic [7:0]  ptr_hi_q [3];
    logic [7:0]  ptr_lo_q [3];
    logic [15:0] instr_q;
    logic        pend_q;
    logic        second_q;
    logic [15:0] first_q;
    logic [11:0] memaddr_q;
    logic [7:0]  opnd_q;
    logic [7:0]  res_q;
    logic        hready_q;
    logic [31:0] hrdata_q;
    fmpl_pkg::fmpl_phase_t phase_q;
    fmpl_pkg::fmpl_op_t    op_q;

    wire busy = pend_q || (phase_q != fmpl_pkg::FMPL_Q1);
    wire wr_ctrl    = wr_stb && wr_addr == `FMPL_OFF_CTRL;
    wire wr_instr   = wr_stb && wr_addr == `FMPL_OFF_INSTR;
    wire wr_wreg    = wr_stb && wr_addr == `FMPL_OFF_WREG;
    wire wr_status  = wr_stb && wr_addr == `FMPL_OFF_STATUS;
    wire wr_bank    = wr_stb && wr_addr == `FMPL_OFF_BANK;
    wire wr_memaddr = wr_stb && wr_addr == `FMPL_OFF_MEMADDR;
    wire wr_memdata = wr_stb && wr_addr == `FMPL_OFF_MEMDATA;

    // ------------------------------------------------------------------------
    // Decode of the held instruction word.
    // ------------------------------------------------------------------------
    logic                 d_bit;
    logic                 a_bit;
    logic [7:0]           f_lit;
    logic [1:0]           psel;
    logic [11:0]          eff_addr;
    fmpl_pkg::fmpl_op_t   dec_op;

    always_comb begin
        d_bit = instr_q[9];
        a_bit = instr_q[8];
        f_lit = instr_q[7:0];
        psel  = first_q[5:4];
        dec_op = fmpl_pkg::FMPL_OP_NONE;
        if (second_q) begin
            dec_op = (first_q[15:12] == `FMPL_OP_MFF_SRC) ? fmpl_pkg::FMPL_OP_FF
                                                         : fmpl_pkg::FMPL_OP_PTR;
        end else if (instr_q[15:10] == `FMPL_OP_IOR) begin
            dec_op = fmpl_pkg::FMPL_OP_OR;
        end else if (instr_q[15:10] == `FMPL_OP_MOVE_FROM_FILE) begin
            dec_op = fmpl_pkg::FMPL_OP_MOVE;
        end else if (instr_q[15:6] == `FMPL_OP_LPTR && instr_q[5:4] != 2'b11) begin
            dec_op = fmpl_pkg::FMPL_OP_PTR;
        end else if (instr_q[15:12] == `FMPL_OP_MFF_SRC) begin
            dec_op = fmpl_pkg::FMPL_OP_FF;
        end
    end

    // Address resolution for the byte-oriented forms.
    always_comb begin
        eff_addr = {bank_q[3:0], f_lit};
        if (!a_bit) begin
            if (ext_q && f_lit <= `FMPL_IDX_LIMIT) begin
                eff_addr = 12'({ptr_hi_q[2][3:0], ptr_lo_q[2]} + {4'h0, f_lit});
            end else if (f_lit < `FMPL_ACC_SPLIT) begin
                eff_addr = {4'h0, f_lit};
            end else begin
                eff_addr = {`FMPL_ACC_HI_BANK, f_lit};
            end
        end
    end

    // Source for file reads: working register is aliased into the space.
    wire [7:0] rd_val = (memaddr_q == `FMPL_WREG_ADDR) ? wreg_q : mem.rdata;

    // ------------------------------------------------------------------------
    // Instruction intake: software writes a word, the core runs it.
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            instr_q <= `FMPL_RST_WORD;
            pend_q  <= 1'b0;
        end else if (wr_instr && !busy) begin
            instr_q <= wr_data[15:0];
            pend_q  <= 1'b1;
        end else if (phase_q == fmpl_pkg::FMPL_Q1) begin
            pend_q  <= 1'b0;
        end
    end

    // Quarter-cycle sequencer, advancing once an instruction is pending.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            phase_q <= fmpl_pkg::FMPL_Q1;
            op_q    <= fmpl_pkg::FMPL_OP_NONE;
        end else begin
            unique case (phase_q)
                fmpl_pkg::FMPL_Q1: begin
                    if (pend_q) begin
                        phase_q <= fmpl_pkg::FMPL_Q2;
                        op_q    <= dec_op;
                    end
                end
                fmpl_pkg::FMPL_Q2: phase_q <= fmpl_pkg::FMPL_Q3;
                fmpl_pkg::FMPL_Q3: phase_q <= fmpl_pkg::FMPL_Q4;
                fmpl_pkg::FMPL_Q4: phase_q <= fmpl_pkg::FMPL_Q1;
                default:           phase_q <= fmpl_pkg::FMPL_Q1;
            endcase
        end
    end

    // Two-word instructions remember their first word between cycles.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            second_q <= 1'b0;
            first_q  <= `FMPL_RST_WORD;
        end else if (phase_q == fmpl_pkg::FMPL_Q4) begin
            if (!second_q && (op_q == fmpl_pkg::FMPL_OP_PTR
                              || op_q == fmpl_pkg::FMPL_OP_FF)) begin
                second_q <= 1'b1;
                first_q  <= instr_q;
            end else begin
                second_q <= 1'b0;
            end
        end
    end

    // The second word of a file-to-file move must keep the source byte it carries.
    wire ff_hold = op_q == fmpl_pkg::FMPL_OP_FF && second_q;

    // Operand read in Q2 and process in Q3.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            memaddr_q <= 12'h000;
            opnd_q    <= `FMPL_RST_BYTE;
            res_q     <= `FMPL_RST_BYTE;
        end else if (phase_q == fmpl_pkg::FMPL_Q1 && pend_q) begin
            if (dec_op == fmpl_pkg::FMPL_OP_FF && !second_q) begin
                memaddr_q <= instr_q[11:0];
            end else if (dec_op == fmpl_pkg::FMPL_OP_FF) begin
                memaddr_q <= instr_q[11:0];
            end else begin
                memaddr_q <= eff_addr;
            end
        end else if (phase_q == fmpl_pkg::FMPL_Q2 && !ff_hold) begin
            opnd_q <= rd_val;
        end else if (phase_q == fmpl_pkg::FMPL_Q3 && !ff_hold) begin
            res_q <= (op_q == fmpl_pkg::FMPL_OP_OR) ? (opnd_q | wreg_q) : opnd_q;
        end else if (wr_memaddr && !busy) begin
            memaddr_q <= wr_data[11:0];
        end
    end

    // Q4 writes to the working register, or software load.
    wire q4 = phase_q == fmpl_pkg::FMPL_Q4;
    wire byte_op = op_q == fmpl_pkg::FMPL_OP_OR || op_q == fmpl_pkg::FMPL_OP_MOVE;
    wire ff_wr = q4 && op_q == fmpl_pkg::FMPL_OP_FF && second_q;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            wreg_q <= `FMPL_RST_BYTE;
        end else if (q4 && byte_op && !d_bit) begin
            wreg_q <= res_q;
        end else if (ff_wr && memaddr_q == `FMPL_WREG_ADDR) begin
            wreg_q <= res_q;
        end else if (wr_wreg && !busy) begin
            wreg_q <= wr_data[7:0];
        end
    end

    // Negative and zero follow the result; the file-to-file move leaves them.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            status_q <= `FMPL_RST_BYTE;
        end else if (q4 && byte_op) begin
            status_q[`FMPL_ST_N_BIT] <= res_q[7];
            status_q[`FMPL_ST_Z_BIT] <= (res_q == 8'h00);
        end else if (wr_status && !busy) begin
            status_q <= wr_data[7:0];
        end
    end

    // Bank select and extended-set enable are software controls.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            bank_q <= `FMPL_RST_BYTE;
            ext_q  <= 1'b0;
        end else begin
            if (wr_bank && !busy) begin
                bank_q <= {4'h0, wr_data[3:0]};
            end
            if (wr_ctrl && !busy) begin
                ext_q <= wr_data[`FMPL_CTRL_EXT_BIT];
            end
        end
    end

    // Pointer registers: high nibble first cycle, low byte second cycle.
    for (genvar p = 0; p < 3; p++) begin : g_ptr
        always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
                ptr_hi_q[p] <= `FMPL_RST_BYTE;
                ptr_lo_q[p] <= `FMPL_RST_BYTE;
            end else if (q4 && op_q == fmpl_pkg::FMPL_OP_PTR) begin
                if (!second_q && instr_q[5:4] == 2'(p)) begin
                    ptr_hi_q[p] <= {4'h0, instr_q[3:0]};
                end else if (second_q && psel == 2'(p)) begin
                    ptr_lo_q[p] <= instr_q[7:0];
                end
            end
        end
    end

    // Memory port: Q4 file writes, else software pokes.
    always_comb begin
        mem.addr  = memaddr_q;
        mem.wdata = wr_data[7:0];
        mem.we    = wr_memdata && !busy;
        if (q4 && byte_op && d_bit) begin
            mem.wdata = res_q;
            mem.we    = 1'b1;
        end else if (ff_wr) begin
            mem.wdata = res_q;
            mem.we    = (memaddr_q != `FMPL_WREG_ADDR);
        end else if (busy) begin
            mem.we    = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Read data path: one-cycle registered answer.
    // ------------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        unique case (32'(rd_addr))
            `FMPL_OFF_CTRL:    rd_mux = {31'h0, ext_q};
            `FMPL_OFF_INSTR:   rd_mux = {16'h0, instr_q};
            `FMPL_OFF_WREG:    rd_mux = {24'h0, wreg_q};
            `FMPL_OFF_STATUS:  rd_mux = {24'h0, status_q};
            `FMPL_OFF_BANK:    rd_mux = {24'h0, bank_q};
            `FMPL_OFF_PTR0:    rd_mux = {16'h0, ptr_hi_q[0], ptr_lo_q[0]};
            `FMPL_OFF_PTR1:    rd_mux = {16'h0, ptr_hi_q[1], ptr_lo_q[1]};
            `FMPL_OFF_PTR2:    rd_mux = {16'h0, ptr_hi_q[2], ptr_lo_q[2]};
            `FMPL_OFF_MEMADDR: rd_mux = {20'h0, memaddr_q};
            `FMPL_OFF_MEMDATA: rd_mux = {24'h0, rd_val};
            `FMPL_OFF_STATE:   rd_mux = {26'h0, second_q, busy, phase_q};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // Registered read data and ready out; no wait states, response tied to OKAY.
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b1;
        end else begin
            hready_q <= 1'b1;
            if (rd_stb) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    assign HRDATA    = hrdata_q;
    assign HREADYOUT = hready_q;
    assign HRESP     = 1'b0;
endmodule : fmpl_exec

// >>> verification/fmpl_exec_checker.sv
// Checker for the execution block, watching its bus ports only.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module fmpl_exec_checker (
    input wire logic        CLK_SYS,    // Clock.
    input wire logic        NRST,       // Reset, active low.
    input wire logic        HSEL,       // Select.
    input wire logic [31:0] HADDR,      // Address.
    input wire logic [1:0]  HTRANS,     // Transfer type.
    input wire logic        HWRITE,     // Write flag.
    input wire logic [2:0]  HSIZE,      // Size.
    input wire logic        HREADY,     // Bus ready.
    input wire logic [31:0] HWDATA,     // Write data.
    input wire logic [31:0] HRDATA,     // Read data.
    input wire logic        HREADYOUT,  // Ready out.
    input wire logic        HRESP       // Response.
);
    // ------------------------------------------------------------------
    // Read address phase detection.
    // ------------------------------------------------------------------
    logic rd_ap;
    assign rd_ap = HSEL && HTRANS[1] && HREADY && !HWRITE;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    AST_READY_HIGH: assert property (HREADYOUT)
        else $error("Ready out went low.");
    AST_RESP_OKAY: assert property (!HRESP)
        else $error("Error response seen.");
    AST_DATA_HOLD: assert property (!rd_ap |=> $stable(HRDATA))
        else $error("Read data moved without a read.");
    AST_UNMAPPED_ZERO: assert property (rd_ap && HADDR >= 32'h2c |=> HRDATA == 32'h0)
        else $error("Unmapped read not zero.");
    AST_STATUS_NZ: assert property (rd_ap && HADDR == 32'hc |=> !(HRDATA[4] && HRDATA[2]))
        else $error("Negative and zero both set.");
    AST_PTR_WIDTH: assert property (rd_ap && HADDR inside {32'h14, 32'h18, 32'h1c}
        |=> HRDATA[31:12] == 20'h0)
        else $error("Pointer wider than twelve bits.");
    AST_BANK_NIBBLE: assert property (rd_ap && HADDR == 32'h10 |=> HRDATA[31:4] == 28'h0)
        else $error("Bank select wider than a nibble.");
    AST_STATE_PHASE: assert property (rd_ap && HADDR == 32'h28 |=> $onehot(HRDATA[3:0]))
        else $error("Phase field not one-hot.");
endmodule : fmpl_exec_checker

bind fmpl_exec fmpl_exec_checker u_fmpl_exec_checker (.CLK_SYS, .NRST, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HSIZE, .HREADY, .HWDATA, .HRDATA, .HREADYOUT, .HRESP);

// >>> verification/fmpl_exec_test.sv
// Testbench for the execution block, driving instructions over the bus.
// Assumes the design and its checker are compiled before it.
`timescale 1ns/1ps
`include "fmpl_consts.svh"
module fmpl_exec_test;
    logic        CLK_SYS = 1'b0;  // Clock.
    logic        NRST = 1'b0;     // Reset.
    logic        HSEL = 1'b0;     // Select.
    logic [31:0] HADDR = 32'h0;   // Address.
    logic [1:0]  HTRANS = 2'h0;   // Transfer type.
    logic        HWRITE = 1'b0;   // Write flag.
    logic [31:0] HWDATA = 32'h0;  // Write data.
    logic [31:0] HRDATA;          // Read data.
    logic        HREADYOUT;       // Ready out, fed back as ready.
    logic        HRESP;           // Response.
    logic [31:0] rv;              // Last read value.
    int          num_errors = 0;  // Mismatches.
    int          n_tests = 0;     // Comparisons.
    int          cyc = 0;         // Cycle count.
    logic [11:0] kt [3] = '{12'hfff, 12'h001, 12'h3ab};  // Pointer literals.

    fmpl_exec u_fmpl_exec (.CLK_SYS, .NRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
        .HREADY(HREADYOUT), .HWDATA, .HRDATA, .HREADYOUT, .HRESP);

    // Clock and hang guard.
    always #4 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            give_verdict();
        end
    end

    // One bus transfer, entered just after a rising edge.
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
        rv = HRDATA;
    endtask : bus

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rv, e);
    endtask : rdc

    task mem(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, `FMPL_OFF_MEMADDR, {20'h0, a});
        bus(1'b1, `FMPL_OFF_MEMDATA, {24'h0, d});
    endtask : mem

    task peek(input logic [11:0] a, input logic [7:0] e);
        bus(1'b1, `FMPL_OFF_MEMADDR, {20'h0, a});
        rdc("mem", `FMPL_OFF_MEMDATA, {24'h0, e});
    endtask : peek

    // Issue one instruction word and poll until the block is idle.
    task exe(input logic [15:0] w);
        int i;
        i = 0;
        bus(1'b1, `FMPL_OFF_INSTR, {16'h0, w});
        do begin
            bus(1'b0, `FMPL_OFF_STATE, 32'h0);
            i++;
        end while (rv[4] !== 1'b0 && i < 40);
        chk("idle", {31'h0, rv[4]}, 32'h0);
    endtask : exe

    task t_or;
        rdc("wreg rst", `FMPL_OFF_WREG, 32'h0);
        bus(1'b1, `FMPL_OFF_WREG, 32'h91);
        bus(1'b1, `FMPL_OFF_STATUS, 32'h0b);
        mem(12'h013, 8'h13);
        exe(16'h1013);
        rdc("or w", `FMPL_OFF_WREG, 32'h93);
        rdc("or st", `FMPL_OFF_STATUS, 32'h1b);
        peek(12'h013, 8'h13);
        bus(1'b1, `FMPL_OFF_WREG, 32'h40);
        bus(1'b1, `FMPL_OFF_BANK, 32'hf5);
        rdc("bank", `FMPL_OFF_BANK, 32'h5);
        mem(12'h520, 8'h01);
        exe(16'h1320);
        peek(12'h520, 8'h41);
        rdc("or w2", `FMPL_OFF_WREG, 32'h40);
        rdc("or st2", `FMPL_OFF_STATUS, 32'h0b);
        $display("or test done");
    endtask : t_or

    task t_move;
        mem(12'hf80, 8'h00);
        exe(16'h5080);
        rdc("mv w", `FMPL_OFF_WREG, 32'h0);
        rdc("mv st", `FMPL_OFF_STATUS, 32'h0f);
        mem(12'h5ff, 8'h80);
        exe(16'h53ff);
        peek(12'h5ff, 8'h80);
        rdc("mv st2", `FMPL_OFF_STATUS, 32'h1b);
        $display("move test done");
    endtask : t_move

    task t_ptr;
        for (int p = 0; p < 3; p++) begin
            exe(16'(16'hee00 | (p << 4) | kt[p][11:8]));
            rdc("ptr hi", `FMPL_OFF_PTR0 + 4 * p, {20'h0, kt[p][11:8], 8'h0});
            exe({8'hf0, kt[p][7:0]});
            rdc("ptr", `FMPL_OFF_PTR0 + 4 * p, {20'h0, kt[p]});
        end
        bus(1'b1, `FMPL_OFF_CTRL, 32'h1);
        mem(12'h3b0, 8'h80);
        exe(16'h5005);
        rdc("idx", `FMPL_OFF_WREG, 32'h80);
        mem(12'h40a, 8'h7f);
        exe(16'h505f);
        rdc("idx max", `FMPL_OFF_WREG, 32'h7f);
        mem(12'hf60, 8'h55);
        exe(16'h5060);
        rdc("acc hi", `FMPL_OFF_WREG, 32'h55);
        bus(1'b1, `FMPL_OFF_CTRL, 32'h0);
        $display("pointer test done");
    endtask : t_ptr

    task t_ff;
        bus(1'b1, `FMPL_OFF_STATUS, 32'h1b);
        mem(12'h123, 8'h33);
        exe(16'hc123);
        exe(16'hf789);
        peek(12'h789, 8'h33);
        mem(12'h000, 8'ha5);
        exe(16'hc000);
        exe(16'hffe8);
        rdc("ff w", `FMPL_OFF_WREG, 32'ha5);
        bus(1'b1, `FMPL_OFF_WREG, 32'h5a);
        exe(16'hcfe8);
        exe(16'hf456);
        peek(12'h456, 8'h5a);
        rdc("ff st", `FMPL_OFF_STATUS, 32'h1b);
        rdc("unmapped", 32'h30, 32'h0);
        rdc("alias", 32'h104, 32'h0);
        $display("file move test done");
    endtask : t_ff

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin
        repeat (4) @(posedge CLK_SYS);
        NRST <= 1'b1;
        @(posedge CLK_SYS);
        t_or();
        t_move();
        t_ptr();
        t_ff();
        give_verdict();
    end
endmodule : fmpl_exec_test
